// *** inc/srw_defs.vh ***
// What this block does
// - First image row read is the 11-bit row start, dark rows excluded.
// - First image column read is the 11-bit column start, dark ones excluded.
// - Window height field counts image rows read; only values of 2 or more.
// - Window width counts image columns; least 9 with one, 17 with two ADCs.
// - Selector bit 0 set: alternate-set horizontal blank count pads each row.
// - Selector bit 0 clear: primary-set horizontal blank count pads each row.
// - Horizontal blank columns come at row start, ahead of pixel data.
// - Selector bit 1 set: alternate vertical blank rows, at least 4 + dark.
// - Vertical blanking may stretch when integration length in rows needs it.
// - Window, blank, integration and selector writes land in pending copies, moved to live at frame start; control and dark writes act at once.
// - While transfer inhibit is set, no pending copy moves to live.
// - Bad frame after window or horizontal blank change suppresses frame and row active.
`ifndef SRW_DEFS_VH
`define SRW_DEFS_VH
`define SRW_ADDR_W        8
`define SRW_DATA_W        16
`define SRW_A_VERSION     8'h00
`define SRW_A_ROW_START   8'h01
`define SRW_A_COL_START   8'h02
`define SRW_A_HEIGHT      8'h03
`define SRW_A_WIDTH       8'h04
`define SRW_A_ALT_HBLANK  8'h05
`define SRW_A_ALT_VBLANK  8'h06
`define SRW_A_PRI_HBLANK  8'h07
`define SRW_A_PRI_VBLANK  8'h08
`define SRW_A_INTEG_ROWS  8'h09
`define SRW_A_CONTROL     8'h0D
`define SRW_A_DARK_CTRL   8'h22
`define SRW_A_SELECTOR    8'hF2
`define SRW_A_STATUS      8'hF3
`define SRW_RST_ROW_START 11'h01C
`define SRW_RST_COL_START 11'h03C
`define SRW_RST_HEIGHT    11'h4B0
`define SRW_RST_WIDTH     11'h640
`define SRW_RST_ALT_HBLK  14'h015C
`define SRW_RST_ALT_VBLK  15'h0020
`define SRW_RST_PRI_HBLK  14'h00AE
`define SRW_RST_PRI_VBLK  15'h0010
`define SRW_RST_INTEG     16'h04D0
`define SRW_RST_SELECTOR  16'h000B
`define SRW_CTL_INHIBIT   15
`define SRW_CTL_SHOW_BAD  8
`define SRW_CTL_TWO_ADC   0
`define SRW_SEL_HSET      0
`define SRW_SEL_VSET      1
`define SRW_DARK_ROWS     3
`define SRW_VBLK_BASE     15'h0004
`define SRW_MIN_HEIGHT    11'h002
`define SRW_MIN_W_ONE_ADC 11'h009
`define SRW_MIN_W_TWO_ADC 11'h011
`endif

// *** verif/srw_regs_monitor.sv ***
`timescale 1ns/1ps
module srw_regs_monitor (
   input wire        i_sys_clk,
   input wire        i_resetn,
   input wire [7:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [15:0] o_rdata_ff,
   input wire        o_frame_valid,
   input wire        o_line_valid,
   input wire        o_frame_start,
   input wire [15:0] o_pixel_col,
   input wire [15:0] o_pixel_row,
   input wire [10:0] o_live_row_start_ff,
   input wire [10:0] o_live_col_start_ff
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   property p_row_live;
      !$past(o_frame_start) |-> $stable(o_live_row_start_ff);
   endproperty
   a_row_live: assert property (p_row_live)
      else $error("live row start moved outside frame start");
   property p_col_live;
      !$past(o_frame_start) |-> $stable(o_live_col_start_ff);
   endproperty
   a_col_live: assert property (p_col_live)
      else $error("live column start moved outside frame start");
   property p_line_in_frame;
      o_line_valid |-> o_frame_valid;
   endproperty
   a_line_in_frame: assert property (p_line_in_frame)
      else $error("line valid outside frame valid");
   property p_fs_pulse;
      o_frame_start |=> !o_frame_start;
   endproperty
   a_fs_pulse: assert property (p_fs_pulse)
      else $error("frame start longer than one cycle");
   property p_fs_row0;
      o_frame_start |-> (o_pixel_row == 16'h0000) &&
                        (o_pixel_col == 16'h0000);
   endproperty
   a_fs_row0: assert property (p_fs_row0)
      else $error("frame start not at raster origin");
   property p_line_end;
      $fell(o_line_valid) |-> o_pixel_col == 16'h0000;
   endproperty
   a_line_end: assert property (p_line_end)
      else $error("line valid ended before row end");
   property p_col_step;
      o_pixel_col != 16'h0000 |-> o_pixel_col == $past(o_pixel_col) + 16'h0001;
   endproperty
   a_col_step: assert property (p_col_step)
      else $error("column counter skipped");
   property p_frame_end;
      $fell(o_frame_valid) |-> o_pixel_col == 16'h0000;
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame valid ended mid row");
   c_line: cover property ($rose(o_line_valid));
   c_read: cover property (i_rd ##1 o_rdata_ff != 16'h0000);
   c_fs: cover property (o_frame_start);
endmodule // srw_regs_monitor

bind srw_regs srw_regs_monitor u_srw_regs_monitor (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_ff(o_rdata_ff),
   .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
   .o_frame_start(o_frame_start), .o_pixel_col(o_pixel_col),
   .o_pixel_row(o_pixel_row), .o_live_row_start_ff(o_live_row_start_ff),
   .o_live_col_start_ff(o_live_col_start_ff));

// *** verif/tb_srw_regs.sv ***
`timescale 1ns/1ps
module tb_srw_regs;
   // Version value is arbitrary.
   localparam [15:0] VER = 16'h3C5A;
   logic        i_sys_clk = 1'b0;
   logic        i_resetn  = 1'b0;
   logic [7:0]  i_addr    = 8'h00;
   logic [15:0] i_wdata   = 16'h0000;
   logic        i_wr      = 1'b0;
   logic        i_rd      = 1'b0;
   wire  [15:0] o_rdata_ff, o_pixel_col, o_pixel_row;
   wire         o_frame_valid, o_line_valid, o_frame_start;
   wire  [10:0] o_live_row_start_ff, o_live_col_start_ff;
   logic [15:0] mdl [0:255];
   logic [15:0] d, m;
   integer      failures = 0, tests_run = 0, cyc = 0, n, k, seed;
   always #12.5 i_sys_clk = ~i_sys_clk;
   srw_regs #(.VERSION_CODE(VER)) u_srw_regs (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_ff(o_rdata_ff),
      .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
      .o_frame_start(o_frame_start), .o_pixel_col(o_pixel_col),
      .o_pixel_row(o_pixel_row), .o_live_row_start_ff(o_live_row_start_ff),
      .o_live_col_start_ff(o_live_col_start_ff));
   task give_verdict;
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] wmask(input logic [7:0] a);
      case (a)
         8'h01, 8'h02, 8'h03, 8'h04: wmask = 16'h07FF;
         8'h05, 8'h07: wmask = 16'h3FFF;
         8'h06, 8'h08: wmask = 16'h7FFF;
         8'h09, 8'h0D, 8'h22, 8'hF2: wmask = 16'hFFFF;
         default: wmask = 16'h0000;
      endcase
   endfunction
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      if (wmask(a) != 16'h0000) mdl[a] = v & wmask(a);
      // Window and horizontal blank writes leave a change pending.
      if (a >= 8'h01 && a <= 8'h07 && a != 8'h06)
         mdl[8'hF3] = mdl[8'hF3] | 16'h0004;
   endtask
   task rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata_ff;
   endtask
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         give_verdict;
      end
   end
   initial begin
      for (n = 0; n < 256; n = n + 1) mdl[n] = 16'h0000;
      mdl[0] = VER; mdl[1] = 16'h001C; mdl[2] = 16'h003C;
      mdl[3] = 16'h04B0; mdl[4] = 16'h0640; mdl[5] = 16'h015C;
      mdl[6] = 16'h0020; mdl[7] = 16'h00AE; mdl[8] = 16'h0010;
      mdl[9] = 16'h04D0; mdl[8'hF2] = 16'h000B; mdl[8'hF3] = 16'h0001;
      seed = $urandom(32'hD149);
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      for (n = 0; n < 10; n = n + 1) begin
         rd(n[7:0]);
         chk(d, mdl[n]);
      end
      rd(8'hF2);
      chk(d, mdl[8'hF2]);
      rd(8'h40);
      chk(d, 16'h0000);
      for (n = 0; n < 14; n = n + 1) begin
         k = (n < 8) ? n : 1 + ($urandom % 7);
         m = ($urandom & wmask(k[7:0])) | 16'h0040;
         wr(k[7:0], m);
         rd(k[7:0]);
         chk(d, mdl[k]);
      end
      rd(8'hF3);
      chk(d, 16'h0005);
      chk({5'h00, o_live_row_start_ff}, 16'h001C);
      chk({5'h00, o_live_col_start_ff}, 16'h003C);
      for (n = 0; n < 6; n = n + 1) begin
         k = (n < 2) ? 8'h08 + n : (n == 2) ? 8'h0D : (n == 3) ? 8'h22
           : (n == 4) ? 8'hF2 : 8'hF3;
         m = $urandom;
         wr(k[7:0], m);
         rd(k[7:0]);
         chk(d, mdl[k]);
      end
      for (n = 0; n < 5000; n = n + 1) begin
         if (o_pixel_row === 16'h0001 && o_pixel_col === 16'h0000) break;
         @(posedge i_sys_clk);
         #1;
      end
      for (k = 0; k < 1948; k = k + 1) begin
         chk(o_pixel_col, k[15:0]);
         chk({o_frame_valid, o_line_valid}, {1'b1, k >= 348});
         @(posedge i_sys_clk);
         #1;
      end
      chk(o_pixel_row, 16'h0002);
      chk({15'h0000, o_frame_start}, 16'h0000);
      give_verdict;
   end
endmodule // tb_srw_regs

// *** verilog/srw_regs.v ***
`timescale 1ns/1ps
`include "srw_defs.vh"
module srw_regs #(
   parameter [15:0] VERSION_CODE = 16'h0A5A
) (
   input  wire        i_sys_clk,
   input  wire        i_resetn,
   input  wire [7:0]  i_addr,
   input  wire [15:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [15:0] o_rdata_ff,
   output wire        o_frame_valid,
   output wire        o_line_valid,
   output wire        o_frame_start,
   output wire [15:0] o_pixel_col,
   output wire [15:0] o_pixel_row,
   output reg  [10:0] o_live_row_start_ff,
   output reg  [10:0] o_live_col_start_ff
);
   // VERSION_CODE default is arbitrary.
   reg  [10:0] row_start_ff;
   reg  [10:0] col_start_ff;
   reg  [10:0] height_ff;
   reg  [10:0] width_ff;
   reg  [13:0] alt_hblk_ff;
   reg  [14:0] alt_vblk_ff;
   reg  [13:0] pri_hblk_ff;
   reg  [14:0] pri_vblk_ff;
   reg  [15:0] integ_ff;
   reg  [15:0] ctrl_ff;
   reg  [15:0] dark_ff;
   reg  [15:0] sel_ff;
   reg  [10:0] l_height_ff;
   reg  [10:0] l_width_ff;
   reg  [13:0] l_hblk_ff;
   reg  [14:0] l_vblk_ff;
   reg  [15:0] l_integ_ff;
   reg  [1:0]  l_sel_ff;
   reg         change_ff;
   reg         bad_ff;
   reg         nxt_change;
   reg  [15:0] nxt_rdata;
   wire        fs;
   wire        fv_raw;
   wire        lv_raw;
   wire        xfer;
   wire        bad_now;
   wire [10:0] min_width;
   wire [10:0] eff_height;
   wire [10:0] eff_width;
   wire [15:0] vmin;
   wire [15:0] vneed;
   wire [15:0] vblk_eff;
   wire [15:0] status;

   assign xfer = fs && !ctrl_ff[`SRW_CTL_INHIBIT];

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         row_start_ff <= `SRW_RST_ROW_START;
         col_start_ff <= `SRW_RST_COL_START;
         height_ff    <= `SRW_RST_HEIGHT;
         width_ff     <= `SRW_RST_WIDTH;
         alt_hblk_ff  <= `SRW_RST_ALT_HBLK;
         alt_vblk_ff  <= `SRW_RST_ALT_VBLK;
         pri_hblk_ff  <= `SRW_RST_PRI_HBLK;
         pri_vblk_ff  <= `SRW_RST_PRI_VBLK;
         integ_ff     <= `SRW_RST_INTEG;
         ctrl_ff      <= 16'h0000;
         dark_ff      <= 16'h0000;
         sel_ff       <= `SRW_RST_SELECTOR;
      end else if (i_wr) begin
         case (i_addr)
            `SRW_A_ROW_START: row_start_ff <= i_wdata[10:0];
            `SRW_A_COL_START: col_start_ff <= i_wdata[10:0];
            `SRW_A_HEIGHT:    height_ff    <= i_wdata[10:0];
            `SRW_A_WIDTH:     width_ff     <= i_wdata[10:0];
            `SRW_A_ALT_HBLANK: alt_hblk_ff <= i_wdata[13:0];
            `SRW_A_ALT_VBLANK: alt_vblk_ff <= i_wdata[14:0];
            `SRW_A_PRI_HBLANK: pri_hblk_ff <= i_wdata[13:0];
            `SRW_A_PRI_VBLANK: pri_vblk_ff <= i_wdata[14:0];
            `SRW_A_INTEG_ROWS: integ_ff    <= i_wdata;
            `SRW_A_CONTROL:    ctrl_ff     <= i_wdata;
            `SRW_A_DARK_CTRL:  dark_ff     <= i_wdata;
            `SRW_A_SELECTOR:   sel_ff      <= i_wdata;
            default: ;
         endcase
      end
   end

   // A window or horizontal blank write marks the next frame as bad.
   always @* begin
      nxt_change = change_ff;
      if (xfer)
         nxt_change = 1'b0;
      if (i_wr && (i_addr >= `SRW_A_ROW_START) &&
          (i_addr <= `SRW_A_PRI_HBLANK) && (i_addr != `SRW_A_ALT_VBLANK))
         nxt_change = 1'b1;
   end

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_live_row_start_ff <= `SRW_RST_ROW_START;
         o_live_col_start_ff <= `SRW_RST_COL_START;
         l_height_ff <= `SRW_RST_HEIGHT;
         l_width_ff  <= `SRW_RST_WIDTH;
         l_hblk_ff   <= `SRW_RST_ALT_HBLK;
         l_vblk_ff   <= `SRW_RST_ALT_VBLK;
         l_integ_ff  <= `SRW_RST_INTEG;
         l_sel_ff    <= 2'b11;
         change_ff   <= 1'b0;
         bad_ff      <= 1'b0;
      end else begin
         change_ff <= nxt_change;
         if (xfer) begin
            o_live_row_start_ff <= row_start_ff;
            o_live_col_start_ff <= col_start_ff;
            l_height_ff <= height_ff;
            l_width_ff  <= width_ff;
            l_hblk_ff   <= sel_ff[`SRW_SEL_HSET] ? alt_hblk_ff
                                                 : pri_hblk_ff;
            l_vblk_ff   <= sel_ff[`SRW_SEL_VSET] ? alt_vblk_ff
                                                 : pri_vblk_ff;
            l_integ_ff  <= integ_ff;
            l_sel_ff    <= sel_ff[1:0];
            bad_ff      <= change_ff && !ctrl_ff[`SRW_CTL_SHOW_BAD];
         end else if (fs) begin
            bad_ff <= 1'b0;
         end
      end
   end

   // Unsupported sizes are raised to the least the readout supports.
   assign min_width  = ctrl_ff[`SRW_CTL_TWO_ADC] ? `SRW_MIN_W_TWO_ADC
                                                 : `SRW_MIN_W_ONE_ADC;
   assign eff_width  = (l_width_ff < min_width) ? min_width : l_width_ff;
   assign eff_height = (l_height_ff < `SRW_MIN_HEIGHT) ? `SRW_MIN_HEIGHT
                                                       : l_height_ff;
   assign vmin  = {1'b0, `SRW_VBLK_BASE} +
                  {13'h0000, dark_ff[`SRW_DARK_ROWS-1:0]};
   assign vneed = (l_integ_ff > {5'h00, eff_height}) ?
                  l_integ_ff - {5'h00, eff_height} : 16'h0000;
   assign vblk_eff = ({1'b0, l_vblk_ff} < vmin) ?
                     ((vneed > vmin) ? vneed : vmin) :
                     ((vneed > {1'b0, l_vblk_ff}) ? vneed
                                                  : {1'b0, l_vblk_ff});

   srw_timing #(
      .CW (16)
   ) u_timing (
      .i_sys_clk        (i_sys_clk),
      .i_resetn         (i_resetn),
      .i_hblank         ({2'b00, l_hblk_ff}),
      .i_width          ({5'h00, eff_width}),
      .i_height         ({5'h00, eff_height}),
      .i_vblank         (vblk_eff),
      .o_line_on_ff     (lv_raw),
      .o_frame_on_ff    (fv_raw),
      .o_frame_start_ff (fs),
      .o_col_ff         (o_pixel_col),
      .o_row_ff         (o_pixel_row)
   );

   // The mask flop only turns at the edge after frame start, so in the
   // frame start cycle the mask it is about to take is used directly.
   assign bad_now = o_frame_start ?
                    (xfer && change_ff && !ctrl_ff[`SRW_CTL_SHOW_BAD]) :
                    bad_ff;
   assign o_frame_valid = fv_raw && !bad_now;
   assign o_line_valid  = lv_raw && !bad_now;
   assign o_frame_start = fs;
   assign status = {13'h0000, change_ff, bad_ff, l_sel_ff[0]};

   always @* begin
      case (i_addr)
         `SRW_A_VERSION:    nxt_rdata = VERSION_CODE;
         `SRW_A_ROW_START:  nxt_rdata = {5'h00, row_start_ff};
         `SRW_A_COL_START:  nxt_rdata = {5'h00, col_start_ff};
         `SRW_A_HEIGHT:     nxt_rdata = {5'h00, height_ff};
         `SRW_A_WIDTH:      nxt_rdata = {5'h00, width_ff};
         `SRW_A_ALT_HBLANK: nxt_rdata = {2'b00, alt_hblk_ff};
         `SRW_A_ALT_VBLANK: nxt_rdata = {1'b0, alt_vblk_ff};
         `SRW_A_PRI_HBLANK: nxt_rdata = {2'b00, pri_hblk_ff};
         `SRW_A_PRI_VBLANK: nxt_rdata = {1'b0, pri_vblk_ff};
         `SRW_A_INTEG_ROWS: nxt_rdata = integ_ff;
         `SRW_A_CONTROL:    nxt_rdata = ctrl_ff;
         `SRW_A_DARK_CTRL:  nxt_rdata = dark_ff;
         `SRW_A_SELECTOR:   nxt_rdata = sel_ff;
         `SRW_A_STATUS:     nxt_rdata = status;
         default:           nxt_rdata = 16'h0000;
      endcase
   end

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_rdata_ff <= 16'h0000;
      else
         o_rdata_ff <= i_rd ? nxt_rdata : 16'h0000;
   end
endmodule // srw_regs

// *** verilog/srw_timing.v ***
`timescale 1ns/1ps
// Walks the live window as a raster: horizontal blank then pixels in each
// row, window rows then vertical blank rows in each frame.
module srw_timing #(
   parameter CW = 16
) (
   input  wire          i_sys_clk,
   input  wire          i_resetn,
   input  wire [CW-1:0] i_hblank,
   input  wire [CW-1:0] i_width,
   input  wire [CW-1:0] i_height,
   input  wire [CW-1:0] i_vblank,
   output reg           o_line_on_ff,
   output reg           o_frame_on_ff,
   output reg           o_frame_start_ff,
   output reg  [CW-1:0] o_col_ff,
   output reg  [CW-1:0] o_row_ff
);
   wire [CW-1:0] row_len;
   wire [CW-1:0] frm_len;
   wire          row_end;
   wire          frm_end;
   reg           nxt_line_on;
   reg           nxt_frame_on;
   wire [CW-1:0] one;

   assign one     = {{(CW-1){1'b0}}, 1'b1};
   assign row_len = i_hblank + i_width;
   assign frm_len = i_height + i_vblank;
   assign row_end = (o_col_ff >= row_len - {{(CW-1){1'b0}}, 1'b1});
   assign frm_end = row_end &&
                    (o_row_ff >= frm_len - {{(CW-1){1'b0}}, 1'b1});

   always @* begin
      nxt_line_on  = 1'b0;
      nxt_frame_on = 1'b0;
      if (!frm_end) begin
         if (!row_end) begin
            nxt_frame_on = (o_row_ff < i_height);
            nxt_line_on  = nxt_frame_on && (o_col_ff + one >= i_hblank);
         end else begin
            nxt_frame_on = (o_row_ff + one < i_height);
            nxt_line_on  = nxt_frame_on && (i_hblank == {CW{1'b0}});
         end
      end else begin
         nxt_frame_on = (i_height != {CW{1'b0}});
         nxt_line_on  = nxt_frame_on && (i_hblank == {CW{1'b0}});
      end
   end

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_col_ff         <= {CW{1'b0}};
         o_row_ff         <= {CW{1'b0}};
         o_line_on_ff     <= 1'b0;
         o_frame_on_ff    <= 1'b0;
         o_frame_start_ff <= 1'b0;
      end else begin
         o_col_ff         <= row_end ? {CW{1'b0}} : o_col_ff + one;
         o_frame_start_ff <= frm_end;
         if (frm_end)
            o_row_ff <= {CW{1'b0}};
         else if (row_end)
            o_row_ff <= o_row_ff + one;
         o_line_on_ff  <= nxt_line_on;
         o_frame_on_ff <= nxt_frame_on;
      end
   end
endmodule // srw_timing
